/* File: sim/stq_monitor.sv */
// link checker: custom trigger pipeline and reset
`timescale 1ns/1ps
module stq_monitor
	import stq_pkg::*;
(
	input wire logic acq_clk,
	input wire logic reset,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic [PAT_W-1:0] pattern_in,
	input wire logic trigger_out
);
	default clocking cb @(posedge acq_clk);
	endclocking
	// quiet: pipe free of reset and pattern steady, else no prediction
	logic [1:0] cnt_reg, cnt_next;
	logic [PAT_W-1:0] pat_reg;
	logic q;
	always_comb
	begin
		cnt_next = (cnt_reg == 2'd3) ? cnt_reg : cnt_reg + 2'd1;
		if (reset || pattern_in != pat_reg)
			cnt_next = 2'd0;
	end
	always_ff @(posedge acq_clk)
	begin
		cnt_reg <= cnt_next;
		pat_reg <= pattern_in;
	end
	assign q = cnt_reg == 2'd3 && pattern_in == pat_reg;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_and_mode: assert property (disable iff (reset)
		q && pattern_in[1:0] == 2'b00 |-> trigger_out == &$past(data_in, 3))
		else $error("and mode");
	chk_or_mode: assert property (disable iff (reset)
		q && pattern_in[1:0] == 2'b01 |-> trigger_out == |$past(data_in, 3))
		else $error("or mode");
	chk_eq_mode: assert property (disable iff (reset)
		q && pattern_in[1:0] == 2'b10
		|-> trigger_out == ($past(data_in[3:0], 3) == pattern_in))
		else $error("compare mode");
	chk_xor_mode: assert property (disable iff (reset)
		q && pattern_in[1:0] == 2'b11 |-> trigger_out == ^$past(data_in, 3))
		else $error("xor mode");
	chk_depth_hold: assert property (disable iff (reset)
		q && $past(cnt_reg) == 2'd3 && $past(data_in, 3) == $past(data_in, 4)
		|-> $stable(trigger_out)) else $error("early trigger change");
	chk_rise_cause: assert property (disable iff (reset)
		$rose(trigger_out) && q && $past(cnt_reg) == 2'd3
		|-> $past(data_in, 3) != $past(data_in, 4)) else $error("stray rise");
	chk_reset_clear: assert property (reset |=> !trigger_out)
		else $error("trigger after reset");
	chk_release_low: assert property ($fell(reset) |-> !trigger_out[*2])
		else $error("trigger at release");
	cov_eq_fire: cover property (trigger_out && pattern_in[1:0] == 2'b10);
	cov_and_fire: cover property (trigger_out && pattern_in[1:0] == 2'b00);
	cov_restart: cover property ($fell(reset));
endmodule // stq_monitor

/* File: sim/tb_top.sv */
// bench for the trigger cascade and the custom trigger link
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
	import stq_pkg::*;
	logic CLK, RST_N, WR, RD, EXT_TRIG, STATE_TRIG, BUF_TRIG, SEG_DONE;
	logic [3:0] ADDR, pat;
	logic [31:0] WDATA, RDATA, rs;
	logic [7:0] PROBE, sig_seen;
	logic [7:0] q[$];
	int err_total, total_checks, nb, ns;
	stq_if lnk();
	stq_seq_trig stq_seq_trig_i (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PROBE(PROBE),
		.EXT_TRIG(EXT_TRIG), .STATE_TRIG(STATE_TRIG), .BUF_TRIG(BUF_TRIG),
		.SEG_DONE(SEG_DONE), .LNK(lnk));
	stq_custom_trig stq_custom_trig_i (.LNK(lnk), .SIG_IN(PROBE),
		.SIG_SEEN(sig_seen));
	stq_monitor stq_monitor_i (.acq_clk(lnk.acq_clk), .reset(lnk.reset),
		.data_in(lnk.data_in), .pattern_in(lnk.pattern_in),
		.trigger_out(lnk.trigger_out));
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic ref_trig(logic [7:0] d, logic [3:0] p);
		case (p[1:0])
			2'b00: return &d;
			2'b01: return |d;
			2'b10: return d[3:0] == p;
			default: return ^d;
		endcase
	endfunction
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] e);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		`CHK(RDATA & m, e)
		@(posedge CLK);
	endtask
	// three probe values, then count buffer and segment pulses
	task automatic seq(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c, input int eb, input int es);
		nb = 0;
		ns = 0;
		PROBE <= a;
		@(posedge CLK);
		PROBE <= b;
		@(posedge CLK);
		PROBE <= c;
		@(posedge CLK);
		PROBE <= 8'h00;
		repeat (12)
		begin
			@(negedge CLK);
			nb += int'(BUF_TRIG === 1'b1);
			ns += int'(SEG_DONE === 1'b1);
		end
		@(posedge CLK);
		`CHK(nb, eb)
		`CHK(ns, es)
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	// watchdog: a hang counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge CLK);
		err_total++;
		test_done();
	end
	// ----------------------------------------
	// stimulus
	// ----------------------------------------
	initial
	begin
		{RST_N, WR, RD, EXT_TRIG, STATE_TRIG} = '0;
		{ADDR, WDATA, PROBE, pat} = '0;
		rs = 32'h08af;
		err_total = 0;
		total_checks = 0;
		repeat (12) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		rd(REG_CTRL, 32'hff, 32'h0);
		rd(REG_NLEVELS, 32'hf, 32'h1);
		rd(REG_STATUS, 32'hf3, 32'h0);
		wr(4'hf, 32'hffff);
		rd(4'hf, 32'hffffffff, 32'h0);
		wr(REG_NLEVELS, 32'h0);
		rd(REG_NLEVELS, 32'hf, 32'h1);
		wr(REG_NLEVELS, 32'hf);
		rd(REG_NLEVELS, 32'hf, 32'ha);
		$display("registers done");
		for (int m = 0; m < 4; m++)
		begin
			pat = (m == 2) ? 4'h6 : 4'(m);
			wr(REG_PATTERN, {28'h0, pat});
			rd(REG_PATTERN, 32'hf, {28'h0, pat});
			q.delete();
			repeat (40)
			begin
				rs = xs(rs);
				// and mode needs dense ones to fire at all
				PROBE <= (m == 0) ? rs[7:0] | rs[15:8] | rs[23:16] : rs[7:0];
				@(negedge CLK);
				q.push_back(PROBE);
				if (q.size() > 3)
				begin
					`CHK(lnk.trigger_out, ref_trig(q.pop_front(), pat))
					`CHK(sig_seen, q[0])
				end
				@(posedge CLK);
			end
			$display("mode %0d done", m);
		end
		wr(REG_CTRL, 32'h1);
		wr(REG_PATTERN, 32'h9);
		rd(REG_PATTERN, 32'hf, {28'h0, pat});
		wr(REG_CTRL, 32'h0);
		for (int i = 0; i < 3; i++)
			wr(REG_LVL_BASE + 4'(i), 32'((i + 1) * 'h1100 + 'hff));
		wr(REG_NLEVELS, 32'h3);
		wr(REG_CTRL, 32'h7);
		seq(8'h11, 8'h22, 8'h33, 0, 0);
		rd(REG_STATUS, 32'h3, 32'h1);
		EXT_TRIG <= 1'b1;
		seq(8'h22, 8'h33, 8'h11, 0, 0);
		rd(REG_STATUS, 32'h3, 32'h3);
		seq(8'h22, 8'h33, 8'h00, 1, 0);
		seq(8'h11, 8'h00, 8'h00, 0, 0);
		seq(8'h33, 8'h00, 8'h00, 1, 1);
		wr(REG_CTRL, 32'h10);
		rd(REG_STATUS, 32'hf3, 32'h0);
		// state flow selected: its trigger passes on exactly once
		wr(REG_CTRL, 32'h9);
		STATE_TRIG <= 1'b1;
		nb = 0;
		repeat (6)
		begin
			@(negedge CLK);
			nb += int'(BUF_TRIG === 1'b1);
		end
		@(posedge CLK);
		STATE_TRIG <= 1'b0;
		`CHK(nb, 1)
		wr(REG_CTRL, 32'h0);
		$display("cascade done");
		test_done();
	end
endmodule // tb_top

/* File: verilog/stq_custom_trig.sv */
// user side custom trigger: pattern-selected decision, three stage pipe
`timescale 1ns/1ps
module stq_custom_trig
	import stq_pkg::*;
(
	stq_if.custom LNK,
	input wire logic [DATA_W-1:0] SIG_IN,
	output logic [DATA_W-1:0] SIG_SEEN
);
	logic [CUST_PIPE-1:0] pipe_reg;
	logic [CUST_PIPE-1:0] pipe_next;
	logic [DATA_W-1:0] d_reg;
	logic hit;

	// ----------------------------------------
	// decision
	// ----------------------------------------
	always_comb
	begin
		// pattern picks the rule at runtime, no rebuild
		case (LNK.pattern_in[1:0])
			2'b00: hit = &d_reg;
			2'b01: hit = |d_reg;
			2'b10: hit = d_reg[PAT_W-1:0] == LNK.pattern_in;
			default: hit = ^d_reg;
		endcase
		pipe_next = {pipe_reg[CUST_PIPE-2:0], hit};
	end

	// acq_clk is the only clock here
	always_ff @(posedge LNK.acq_clk)
	begin
		if (LNK.reset)
		begin
			pipe_reg <= '0;
			d_reg <= '0;
		end
		else
		begin
			pipe_reg <= pipe_next;
			d_reg <= LNK.data_in;
		end
	end

	// input reg + two more stages = CUST_PIPE cycles
	assign LNK.trigger_out = pipe_reg[CUST_PIPE-2];
	always_ff @(posedge LNK.acq_clk)
	begin
		SIG_SEEN <= d_reg;
	end
endmodule // stq_custom_trig

/* File: verilog/stq_if.sv */
// link between the analyzer trigger unit and the custom trigger module
`timescale 1ns/1ps
interface stq_if;
	import stq_pkg::*;
	logic acq_clk;
	logic reset;
	logic [DATA_W-1:0] data_in;
	logic [PAT_W-1:0] pattern_in;
	logic trigger_out;
	modport analyzer (output acq_clk, output reset, output data_in,
		output pattern_in, input trigger_out);
	modport custom (input acq_clk, input reset, input data_in,
		input pattern_in, output trigger_out);
endinterface

/* File: verilog/stq_pkg.sv */
// shared constants and types for the sequential trigger and custom trigger
package stq_pkg;
	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int PAT_W = 4;
	localparam int MAX_LEVELS = 10;
	localparam int LVL_W = 4;
	// ----------------------------------------
	// custom trigger pipeline depth in cycles
	// ----------------------------------------
	localparam int CUST_PIPE = 3;
	// ----------------------------------------
	// register map of the analyzer control port
	// ----------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_NLEVELS = 4'h1;
	localparam logic [3:0] REG_PATTERN = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_LVL_BASE = 4'h4;
	localparam logic [3:0] REG_EXT_COND = 4'he;
	// ctrl bit positions
	localparam int CTRL_RUN = 0;
	localparam int CTRL_EXT_EN = 1;
	localparam int CTRL_SEGMENTED = 2;
	localparam int CTRL_STATE_MODE = 3;
	localparam int CTRL_RESTART = 4;
	// level condition fields: [7:0] mask, [15:8] value, [16] use custom
	localparam int LC_MASK_LSB = 0;
	localparam int LC_VAL_LSB = 8;
	localparam int LC_CUST = 16;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [3:0] NLEVELS_RST = 4'h1;
	localparam logic [16:0] LVL_RST = 17'h00000;
	localparam logic [PAT_W-1:0] PATTERN_RST = 4'h0;
	localparam logic [7:0] SEG_CNT_RST = 8'h00;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_EXT = 2'b01,
		ST_LEVELS = 2'b11,
		ST_DONE = 2'b10
	} stq_state_t;
endpackage

/* File: verilog/stq_seq_trig.sv */
// analyzer end: sequential trigger cascade driving the custom trigger link
// ----------------------------------------
// Functional notes
// - custom module clocked by acquisition clock
// - capture restart resets the custom module
// - custom decision based on data bus
// - runtime pattern changes custom behaviour
// - custom module gives one trigger bit
// - pattern width equals configured bit count
// - empty pattern means no pattern connected
// - analyzer aligns data to custom pipeline
// - one to ten levels, all satisfied
// - levels evaluated in order, last triggers
// - later segments trigger on last level
// - external trigger is level zero, first
// - sequential flow is the default mode
// - each level basic or advanced condition
// - both flows with segmented buffers
// ----------------------------------------
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module stq_seq_trig
	import stq_pkg::*;
#(
	parameter bit HAS_PATTERN = 1'b1
)
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [3:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic [DATA_W-1:0] PROBE,
	input wire logic EXT_TRIG,
	input wire logic STATE_TRIG,
	output logic BUF_TRIG,
	output logic SEG_DONE,
	stq_if.analyzer LNK
);
	import stq_pkg::*;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] ctrl_reg, ctrl_next;
	logic [LVL_W-1:0] nlev_reg, nlev_next;
	logic [PAT_W-1:0] pat_reg, pat_next;
	logic [16:0] lvl_reg [MAX_LEVELS];
	logic [16:0] lvl_next [MAX_LEVELS];
	logic [31:0] rdata_reg, rdata_next;
	logic cust_rst_reg, cust_rst_next;
	stq_state_t state_reg, state_next;
	logic [LVL_W-1:0] ptr_reg, ptr_next;
	logic first_seg_reg, first_seg_next;
	logic [7:0] seg_cnt_reg, seg_cnt_next;
	logic trig_reg, trig_next;
	logic seg_done_reg, seg_done_next;
	logic [DATA_W-1:0] dly_reg [CUST_PIPE];
	logic restart;
	logic cond_now;
	logic [LVL_W-1:0] last_lvl;

	// a level matches when masked probe equals value, or on the custom bit alone when LC_CUST is set
	function automatic logic lvl_match(input logic [16:0] c,
		input logic [DATA_W-1:0] d, input logic cust);
		logic basic;
		basic = ((d ^ c[LC_VAL_LSB +: DATA_W]) & c[LC_MASK_LSB +: DATA_W])
			== '0;
		lvl_match = c[LC_CUST] ? cust : basic;
	endfunction

	assign restart = WR && ADDR == REG_CTRL && WDATA[CTRL_RESTART];
	assign last_lvl = nlev_reg - 4'h1;

	// ----------------------------------------
	// register port
	// ----------------------------------------
	always_comb
	begin
		ctrl_next = ctrl_reg;
		nlev_next = nlev_reg;
		pat_next = pat_reg;
		lvl_next = lvl_reg;
		rdata_next = 32'h0;
		cust_rst_next = restart;
		if (WR)
		begin
			if (ADDR == REG_CTRL)
				ctrl_next = WDATA[7:0];
			else if (ADDR == REG_NLEVELS)
			begin
				// clamp to 1..10
				if (WDATA[3:0] == 4'h0)
					nlev_next = 4'h1;
				else if (WDATA[3:0] > 4'ha)
					nlev_next = 4'ha;
				else
					nlev_next = WDATA[3:0];
			end
			else if (ADDR == REG_PATTERN && !ctrl_reg[CTRL_RUN])
				pat_next = WDATA[PAT_W-1:0];
			else if (ADDR >= REG_LVL_BASE && ADDR < REG_EXT_COND)
				lvl_next[ADDR - REG_LVL_BASE] = WDATA[16:0];
		end
		if (RD)
		begin
			if (ADDR == REG_CTRL)
				rdata_next = {24'h0, ctrl_reg};
			else if (ADDR == REG_NLEVELS)
				rdata_next = {28'h0, nlev_reg};
			else if (ADDR == REG_PATTERN)
				rdata_next = {28'h0, pat_reg};
			else if (ADDR == REG_STATUS)
				rdata_next = {16'h0, seg_cnt_reg, ptr_reg, 1'b0,
					first_seg_reg, state_reg};
			else if (ADDR >= REG_LVL_BASE && ADDR < REG_EXT_COND)
				rdata_next = {15'h0, lvl_reg[ADDR - REG_LVL_BASE]};
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			ctrl_reg <= CTRL_RST; // sequential is default
			nlev_reg <= NLEVELS_RST;
			pat_reg <= PATTERN_RST;
			for (int i = 0; i < MAX_LEVELS; i++)
				lvl_reg[i] <= LVL_RST;
			rdata_reg <= 32'h0;
			cust_rst_reg <= 1'b1;
		end
		else
		begin
			ctrl_reg <= {ctrl_next[7:5], 1'b0, ctrl_next[3:0]};
			nlev_reg <= nlev_next;
			pat_reg <= pat_next;
			lvl_reg <= lvl_next;
			rdata_reg <= rdata_next;
			cust_rst_reg <= cust_rst_next;
		end
	end

	// ----------------------------------------
	// probe delay to line up with custom pipe
	// ----------------------------------------
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < CUST_PIPE; i++)
				dly_reg[i] <= '0;
		end
		else
		begin
			// probe waits CUST_PIPE cycles so both agree
			dly_reg[0] <= PROBE;
			for (int i = 1; i < CUST_PIPE; i++)
				dly_reg[i] <= dly_reg[i-1];
		end
	end

	// ----------------------------------------
	// sequential cascade
	// ----------------------------------------
	always_comb
	begin
		state_next = state_reg;
		ptr_next = ptr_reg;
		first_seg_next = first_seg_reg;
		seg_cnt_next = seg_cnt_reg;
		trig_next = 1'b0;
		cond_now = lvl_match(lvl_reg[ptr_reg], dly_reg[CUST_PIPE-1],
			LNK.trigger_out);
		case (state_reg)
			ST_IDLE:
			begin
				if (ctrl_reg[CTRL_RUN])
					// external trigger goes first
					state_next = ctrl_reg[CTRL_EXT_EN] ? ST_EXT : ST_LEVELS;
				ptr_next = first_seg_reg ? 4'h0 : last_lvl;
			end
			ST_EXT:
			begin
				if (EXT_TRIG)
					state_next = ST_LEVELS;
			end
			ST_LEVELS:
			begin
				if (ctrl_reg[CTRL_STATE_MODE])
				begin
					// state flow lives elsewhere; pass its trigger on
					if (STATE_TRIG)
					begin
						trig_next = 1'b1;
						state_next = ST_DONE;
					end
				end
				else if (cond_now)
				begin
					if (ptr_reg >= last_lvl)
					begin
						trig_next = 1'b1;
						state_next = ST_DONE;
					end
					else
						ptr_next = ptr_reg + 4'h1; // one step
				end
			end
			default:
			begin
				// segmented: re-arm on last level only
				if (ctrl_reg[CTRL_SEGMENTED])
				begin
					first_seg_next = 1'b0;
					seg_cnt_next = seg_cnt_reg + 8'h01;
					ptr_next = last_lvl;
					state_next = ST_LEVELS;
				end
			end
		endcase
		if (restart || !ctrl_reg[CTRL_RUN])
		begin
			state_next = ST_IDLE;
			ptr_next = 4'h0;
			first_seg_next = 1'b1;
			seg_cnt_next = SEG_CNT_RST;
		end
		// registered so the pin comes straight from a flop
		seg_done_next = trig_next && !first_seg_reg;
	end

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			state_reg <= ST_IDLE;
			ptr_reg <= 4'h0;
			first_seg_reg <= 1'b1;
			seg_cnt_reg <= SEG_CNT_RST;
			trig_reg <= 1'b0;
			seg_done_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			seg_done_reg <= seg_done_next;
			ptr_reg <= ptr_next;
			first_seg_reg <= first_seg_next;
			seg_cnt_reg <= seg_cnt_next;
			trig_reg <= trig_next;
		end
	end

	// ----------------------------------------
	// outputs and link
	// ----------------------------------------
	assign RDATA = rdata_reg;
	assign BUF_TRIG = trig_reg;
	assign SEG_DONE = seg_done_reg;
	assign LNK.acq_clk = CLK;
	assign LNK.reset = cust_rst_reg; // restart pulses it
	assign LNK.data_in = PROBE;
	// no pattern configured: drive zero, leave input unused
	assign LNK.pattern_in = HAS_PATTERN ? pat_reg : '0;
endmodule // stq_seq_trig
